// [pkg/mgmt_regs_params.svh]
`ifndef MGMT_REGS_PARAMS_SVH
`define MGMT_REGS_PARAMS_SVH
// register addresses of the direct space
`define REG_BASIC_CONTROL 5'h00
`define REG_BASIC_STATUS 5'h01
`define REG_ID_HIGH 5'h02
`define REG_ID_LOW 5'h03
`define REG_ADVERTISE 5'h04
`define REG_PARTNER_ABILITY 5'h05
`define REG_EXPANSION 5'h06
`define REG_NEXT_PAGE 5'h07
`define REG_PARTNER_NEXT_PAGE 5'h08
`define REG_GIGABIT_CONTROL 5'h09
`define REG_GIGABIT_STATUS 5'h0a
`define REG_EXT_CONTROL 5'h0b
`define REG_EXT_WRITE 5'h0c
`define REG_EXT_READ 5'h0d
`define REG_EXT_LINK_STATUS 5'h0f
`define REG_LOOPBACK_INDICATOR 5'h11
`define REG_CABLE_DIAG 5'h12
`define REG_CODING_STATUS 5'h13
`define REG_RX_ERROR_COUNT 5'h15
`define REG_IRQ_CONTROL 5'h1b
`define REG_DEBUG_ONE 5'h1c
`define REG_DEVICE_CONTROL 5'h1f
// extended register addresses
`define EXT_STRAP_READBACK 15'h0101
`define EXT_OP_MODE_OVERRIDE 15'h0102
`define EXT_OP_MODE_READBACK 15'h0103
`define EXT_ANALOG_TEST 15'h0107
// field positions
`define BIT_SOFT_RESET 15
`define BIT_AUTONEG_EN 12
`define BIT_POWER_DOWN 11
`define BIT_EXT_WRITE_SEL 15
// reset values
`define RST_BASIC_CONTROL 16'h1000
`define RST_BASIC_STATUS 16'h7900
`define RST_ZERO 16'h0000
// mode strap codes and override code
`define MODE_NAND_TREE 4'h4
`define MODE_CHIP_DOWN 4'h7
`define OVERRIDE_NAND_TREE 16'h0010
// frame layout
`define PREAMBLE_ONES 6'd32
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define START_PATTERN 2'b01
// management clock divider half period in system clocks
`define MDC_HALF_CYCLES 8'd4
`endif

// [pkg/mgmt_pkg.sv]
package mgmt_pkg;
    // device end frame states, gray along the frame
    typedef enum logic [2:0] {
        D_PRE = 3'b000,
        D_HDR = 3'b001,
        D_TA = 3'b011,
        D_DATA = 3'b010,
        D_WAIT = 3'b110
    } dev_state_t;
    // controller end states
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_SHIFT = 3'b001,
        C_TURN = 3'b011,
        C_DATA = 3'b010,
        C_DONE = 3'b110
    } ctl_state_t;
endpackage

// [pkg/mgmt_if.sv]
`timescale 1ns/10ps
// management link: clock from controller, data line shared
interface mgmt_if;
    logic mdc;        // management clock level
    logic mdio_ctl_o; // controller drive value
    logic mdio_ctl_oe;
    logic mdio_dev_o; // device drive value
    logic mdio_dev_oe;
    logic mdio;       // resolved line, pulled high
    assign mdio = mdio_ctl_oe ? mdio_ctl_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);
    modport controller (output mdc, output mdio_ctl_o, output mdio_ctl_oe, input mdio);
    modport device (input mdc, output mdio_dev_o, output mdio_dev_oe, input mdio);
endinterface // mgmt_if

// [rtl/mgmt_device.sv]
`timescale 1ns/10ps
`include "mgmt_regs_params.svh"
// Overview of operation
// - straps 0100 at reset select nand tree
// - chain pins in order onto test output
// - power saving when autoneg on, no link
// - bit 11 of register 0 powers down
// - power down keeps management interface alive
// - clearing bit 11 resumes operation
// - straps 0111 at reset select chip power down
// - leave chip power down only by reset
// - decode 32 direct registers, two halves
// - extended access via registers 11, 12, 13
// - control with top bit clear selects read
// - control with top bit set, then data write
// - implement extended registers 257, 258, 259, 263
// - override 0010h forces nand tree mode
// - frame: preamble, start, opcode, addresses, data
module mgmt_device #(
    parameter logic [4:0] DEV_ADDR = 5'h01,
    parameter logic [15:0] ID_HIGH = 16'h1234, // arbitrary value
    parameter logic [15:0] ID_LOW = 16'h5678   // arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mgmt_if.device link,
    input wire logic [3:0] mode_strap_i,        // operation-mode straps
    input wire logic cable_link_i,              // cable link present
    input wire logic [29:0] tree_chain_inputs_i, // pins in chain order
    output logic tree_test_output_pin_o,
    output logic power_down_o,                  // software power down
    output logic chip_down_o,                   // chip power down
    output logic power_saving_o,
    output logic nand_tree_o
);
    // all state in one struct
    typedef struct packed {
        mgmt_pkg::dev_state_t st;
        logic mdc_d;          // previous clock level
        logic [5:0] cnt;      // bit counter
        logic [13:0] hdr;     // start, op, addresses
        logic [15:0] shreg;   // data shift
        logic rd;             // frame is a read
        logic mine;           // frame addressed to us
        logic oe;
        logic dout;
        logic strap_taken;    // straps captured once after reset
        logic [3:0] strap;
        logic [15:0] ctrl;    // basic control
        logic [15:0] adv;
        logic [15:0] npage;
        logic [15:0] gctl;
        logic [15:0] extc;    // extended access control
        logic [15:0] extw;    // last written data
        logic [15:0] ovr;     // op mode override
        logic [15:0] atest;
        logic [15:0] ledm;
        logic [15:0] dbg;
        logic [15:0] devc;
        logic [15:0] irqc;
        logic tree;
        logic chip;
        logic save;
        logic tout;
    } dev_t;
    dev_t r, nxt;

    // extended space read
    function automatic logic [15:0] ext_read(input dev_t s);
        case (s.extc[14:0])
            `EXT_STRAP_READBACK: ext_read = {12'h000, s.strap};
            `EXT_OP_MODE_OVERRIDE: ext_read = s.ovr;
            `EXT_OP_MODE_READBACK: ext_read = {12'h000, s.strap};
            `EXT_ANALOG_TEST: ext_read = s.atest;
            default: ext_read = `RST_ZERO;
        endcase
    endfunction

    // direct space read
    function automatic logic [15:0] reg_read(input dev_t s, input logic [4:0] a);
        case (a)
            `REG_BASIC_CONTROL: reg_read = s.ctrl;
            `REG_BASIC_STATUS: reg_read = `RST_BASIC_STATUS | {13'h0, s.save ? 1'b0 : 1'b1, 2'b00};
            `REG_ID_HIGH: reg_read = ID_HIGH;
            `REG_ID_LOW: reg_read = ID_LOW;
            `REG_ADVERTISE: reg_read = s.adv;
            `REG_NEXT_PAGE: reg_read = s.npage;
            `REG_GIGABIT_CONTROL: reg_read = s.gctl;
            `REG_EXT_CONTROL: reg_read = s.extc;
            `REG_EXT_WRITE: reg_read = s.extw;
            `REG_EXT_READ: reg_read = ext_read(s);
            `REG_LOOPBACK_INDICATOR: reg_read = s.ledm;
            `REG_IRQ_CONTROL: reg_read = s.irqc;
            `REG_DEBUG_ONE: reg_read = s.dbg;
            `REG_DEVICE_CONTROL: reg_read = s.devc;
            default: reg_read = `RST_ZERO;
        endcase
    endfunction

    // next state
    always_comb begin
        logic rise;
        logic fall;
        logic [15:0] wd;
        rise = 1'b0;
        fall = 1'b0;
        wd = 16'h0000;
        nxt = r;
        rise = link.mdc & ~r.mdc_d;
        fall = ~link.mdc & r.mdc_d;
        nxt.mdc_d = link.mdc;
        // straps caught once after reset release
        if (!r.strap_taken) begin
            nxt.strap_taken = 1'b1;
            nxt.strap = mode_strap_i;
            nxt.tree = (mode_strap_i == `MODE_NAND_TREE);
            nxt.chip = (mode_strap_i == `MODE_CHIP_DOWN);
        end
        if (rise) begin
            unique case (r.st)
                mgmt_pkg::D_PRE: begin
                    if (link.mdio) begin
                        nxt.cnt = (r.cnt == `PREAMBLE_ONES) ? r.cnt : r.cnt + 6'd1;
                    end else if (r.cnt == `PREAMBLE_ONES) begin
                        nxt.st = mgmt_pkg::D_HDR;
                        nxt.hdr = 14'h0000;
                        nxt.cnt = 6'd0;
                    end else begin
                        nxt.cnt = 6'd0;
                    end
                end
                mgmt_pkg::D_HDR: begin
                    nxt.hdr = {r.hdr[12:0], link.mdio};
                    nxt.cnt = r.cnt + 6'd1;
                    if (r.cnt == 6'd12) begin
                        nxt.st = mgmt_pkg::D_TA;
                        nxt.cnt = 6'd0;
                        // hdr holds start bit, opcode, device address, top 4 reg bits
                        nxt.rd = (r.hdr[10:9] == `OP_READ);
                        nxt.mine = (r.hdr[8:4] == DEV_ADDR) &&
                            (r.hdr[10:9] == `OP_READ || r.hdr[10:9] == `OP_WRITE);
                        nxt.shreg = reg_read(r, {r.hdr[3:0], link.mdio});
                    end
                end
                mgmt_pkg::D_TA: begin
                    nxt.cnt = r.cnt + 6'd1;
                    if (r.cnt == 6'd1) begin
                        nxt.st = mgmt_pkg::D_DATA;
                        nxt.cnt = 6'd0;
                    end
                end
                mgmt_pkg::D_DATA: begin
                    nxt.cnt = r.cnt + 6'd1;
                    if (!r.rd) begin
                        nxt.shreg = {r.shreg[14:0], link.mdio};
                    end
                    if (r.cnt == 6'd15) begin
                        nxt.st = mgmt_pkg::D_WAIT;
                        nxt.cnt = 6'd0;
                    end
                end
                mgmt_pkg::D_WAIT: begin
                    nxt.st = mgmt_pkg::D_PRE;
                end
            endcase
        end
        // read data driven on falling edge
        if (fall) begin
            nxt.oe = 1'b0;
            if (r.rd && r.mine) begin
                if (r.st == mgmt_pkg::D_TA && r.cnt == 6'd1) begin
                    nxt.oe = 1'b1;
                    nxt.dout = 1'b0;
                end else if (r.st == mgmt_pkg::D_DATA) begin
                    nxt.oe = 1'b1;
                    nxt.dout = r.shreg[15];
                    nxt.shreg = {r.shreg[14:0], 1'b0};
                end
            end
        end
        // write commit at frame end; still works in power down
        if (r.st == mgmt_pkg::D_WAIT && rise && r.mine && !r.rd) begin
            wd = r.shreg;
            case (r.hdr[4:0])
                `REG_BASIC_CONTROL: begin
                    nxt.ctrl = wd;
                    if (wd[`BIT_SOFT_RESET]) begin
                        nxt.ctrl = `RST_BASIC_CONTROL; // self-clearing soft reset
                    end
                end
                `REG_ADVERTISE: nxt.adv = wd;
                `REG_NEXT_PAGE: nxt.npage = wd;
                `REG_GIGABIT_CONTROL: nxt.gctl = wd;
                `REG_EXT_CONTROL: nxt.extc = wd;
                `REG_EXT_WRITE: begin
                    nxt.extw = wd;
                    if (r.extc[`BIT_EXT_WRITE_SEL]) begin
                        case (r.extc[14:0])
                            `EXT_OP_MODE_OVERRIDE: begin
                                nxt.ovr = wd;
                                if (wd == `OVERRIDE_NAND_TREE) begin
                                    nxt.tree = 1'b1;
                                end
                            end
                            `EXT_ANALOG_TEST: nxt.atest = wd;
                            default: ;
                        endcase
                    end
                end
                `REG_LOOPBACK_INDICATOR: nxt.ledm = wd;
                `REG_IRQ_CONTROL: nxt.irqc = {wd[15:8], r.irqc[7:0]};
                `REG_DEBUG_ONE: nxt.dbg = wd;
                `REG_DEVICE_CONTROL: nxt.devc = wd;
                default: ;
            endcase
        end
        // nand tree output chain
        nxt.tout = 1'b1;
        for (int i = 0; i < 30; i++) begin
            nxt.tout = ~(nxt.tout & tree_chain_inputs_i[i]);
        end
        nxt.tout = nxt.tout & nxt.tree; // held low outside tree mode
        nxt.save = r.ctrl[`BIT_AUTONEG_EN] & ~cable_link_i;
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= mgmt_pkg::D_PRE;
            r.mdc_d <= 1'b1;
            r.ctrl <= `RST_BASIC_CONTROL;
            r.ledm <= 16'h00c0;
        end else begin
            r <= nxt;
        end
    end

    assign link.mdio_dev_o = r.dout;
    assign link.mdio_dev_oe = r.oe;
    assign tree_test_output_pin_o = r.tout;
    assign power_down_o = r.ctrl[`BIT_POWER_DOWN];
    assign chip_down_o = r.chip;
    assign power_saving_o = r.save;
    assign nand_tree_o = r.tree;
endmodule // mgmt_device

// [rtl/mgmt_controller.sv]
`timescale 1ns/10ps
`include "mgmt_regs_params.svh"
// management controller: one frame per request
module mgmt_controller #(
    parameter logic [4:0] DEV_ADDR = 5'h01
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mgmt_if.controller link,
    input wire logic req_i,         // start a frame, taken when idle
    input wire logic write_i,       // 1 write, 0 read
    input wire logic [4:0] reg_i,
    input wire logic [15:0] wdata_i,
    output logic busy_o,
    output logic done_o,            // one-cycle pulse
    output logic [15:0] rdata_o
);
    // all state in one struct
    typedef struct packed {
        mgmt_pkg::ctl_state_t st;
        logic [7:0] div;
        logic mdc;
        logic [5:0] cnt;
        logic [45:0] sh;   // preamble, header, data
        logic wr;
        logic oe;
        logic [15:0] rdat;
        logic done;
    } ctl_t;
    ctl_t r, nxt;

    // next state; changes on falling mdc, samples on rising
    always_comb begin
        logic tick;
        tick = 1'b0;
        nxt = r;
        nxt.done = 1'b0;
        tick = (r.div == `MDC_HALF_CYCLES - 8'd1);
        if (r.st != mgmt_pkg::C_IDLE && r.st != mgmt_pkg::C_DONE) begin
            nxt.div = tick ? 8'd0 : r.div + 8'd1;
            if (tick) begin
                nxt.mdc = ~r.mdc;
            end
        end
        unique case (r.st)
            mgmt_pkg::C_IDLE: begin
                if (req_i) begin
                    nxt.st = mgmt_pkg::C_SHIFT;
                    nxt.wr = write_i;
                    nxt.sh = {{`PREAMBLE_ONES{1'b1}}, `START_PATTERN,
                        write_i ? `OP_WRITE : `OP_READ, DEV_ADDR, reg_i};
                    nxt.cnt = 6'd0;
                    nxt.oe = 1'b1;
                    nxt.div = 8'd0;
                    nxt.mdc = 1'b0;
                    nxt.rdat = wdata_i;
                end
            end
            mgmt_pkg::C_SHIFT: begin
                if (tick && r.mdc) begin
                    nxt.sh = {r.sh[44:0], 1'b0};
                    nxt.cnt = r.cnt + 6'd1;
                    if (r.cnt == 6'd45) begin
                        nxt.st = mgmt_pkg::C_TURN;
                        nxt.cnt = 6'd0;
                        nxt.oe = r.wr;
                        nxt.sh = {r.wr ? 2'b10 : 2'b00, r.rdat, 28'h0};
                    end
                end
            end
            mgmt_pkg::C_TURN: begin
                if (tick && r.mdc) begin
                    nxt.sh = {r.sh[44:0], 1'b0};
                    nxt.cnt = r.cnt + 6'd1;
                    if (r.cnt == 6'd1) begin
                        nxt.st = mgmt_pkg::C_DATA;
                        nxt.cnt = 6'd0;
                    end
                end
            end
            mgmt_pkg::C_DATA: begin
                if (tick && !r.mdc) begin
                    // the rise after the last data bit carries no data
                    if (!r.wr && r.cnt < 6'd16) begin
                        nxt.rdat = {r.rdat[14:0], link.mdio};
                    end
                end
                if (tick && r.mdc) begin
                    nxt.sh = {r.sh[44:0], 1'b0};
                    nxt.cnt = r.cnt + 6'd1;
                    if (r.cnt == 6'd16) begin
                        nxt.st = mgmt_pkg::C_DONE;
                        nxt.oe = 1'b0;
                        nxt.done = 1'b1;
                    end
                end
            end
            mgmt_pkg::C_DONE: begin
                nxt.st = mgmt_pkg::C_IDLE;
            end
            default: nxt.st = mgmt_pkg::C_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= mgmt_pkg::C_IDLE;
            r.mdc <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    assign link.mdc = r.mdc;
    assign link.mdio_ctl_o = r.sh[45];
    assign link.mdio_ctl_oe = r.oe;
    assign busy_o = (r.st != mgmt_pkg::C_IDLE);
    assign done_o = r.done;
    assign rdata_o = r.rdat;
endmodule // mgmt_controller

// [tb/mgmt_props.sv]
`timescale 1ns/10ps
// watches the management link between the two ends
module mgmt_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mdc,
    input wire logic mdio_ctl_o,
    input wire logic mdio_ctl_oe,
    input wire logic mdio_dev_o,
    input wire logic mdio_dev_oe,
    input wire logic mdio
);
    logic mdc_d_r; // mdc one clock ago
    logic [3:0] idle_r; // clocks since mdc last moved, saturating
    logic [6:0] bit_r; // index of the frame bit at the next mdc rise
    logic [1:0] op_r; // opcode bits as they pass
    logic rise; // mdc seen rising this clock
    assign rise = mdc & ~mdc_d_r;
    // tracks the frame bit position; a quiet mdc restarts the count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_d_r <= 1'b1;
            idle_r <= 4'hf;
            bit_r <= 7'h00;
            op_r <= 2'h0;
        end else begin
            mdc_d_r <= mdc;
            if (mdc != mdc_d_r) begin
                idle_r <= 4'h0;
            end else if (idle_r != 4'hf) begin
                idle_r <= idle_r + 4'h1;
            end
            // count bits on rises, clear once the link rests
            if (rise) begin
                bit_r <= bit_r + 7'h01;
            end else if (idle_r == 4'hf) begin
                bit_r <= 7'h00;
            end
            // opcode is bits 34 and 35
            if (rise && (bit_r == 7'd34 || bit_r == 7'd35)) begin
                op_r <= {op_r[0], mdio};
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_single_driver: assert property (!(mdio_ctl_oe && mdio_dev_oe))
        else $error("both ends drive the data line");
    a_mdc_half_period: assert property ($changed(mdc) |=> $stable(mdc)[*3])
        else $error("management clock half period too short");
    a_preamble_ones: assert property (rise && bit_r < 7'd32 |-> mdio)
        else $error("preamble bit not one");
    a_start_zero: assert property (rise && bit_r == 7'd32 |-> !mdio)
        else $error("start pattern first bit not zero");
    a_start_one: assert property (rise && bit_r == 7'd33 |-> mdio)
        else $error("start pattern second bit not one");
    a_read_turnaround: assert property (rise && bit_r == 7'd47 && op_r == 2'b10
        |-> mdio_dev_oe && !mdio && !mdio_ctl_oe)
        else $error("read turnaround not driven low by device");
    a_write_turnaround: assert property (rise && bit_r == 7'd46 && op_r == 2'b01
        |-> mdio_ctl_oe && mdio ##8 (rise && !mdio))
        else $error("write turnaround not one then zero");
    a_read_data_dev: assert property (rise && bit_r >= 7'd48 && bit_r <= 7'd63
        && op_r == 2'b10 |-> mdio_dev_oe && !mdio_ctl_oe)
        else $error("device not driving read data");
    a_write_dev_quiet: assert property (rise && bit_r >= 7'd36 && op_r == 2'b01
        |-> !mdio_dev_oe)
        else $error("device drives during a write");
endmodule // mgmt_props

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "mgmt_regs_params.svh"
// bench joining controller and device over the management link
module tb_top;
    logic clk_i;
    logic rst_i;
    logic req_i;
    logic write_i;
    logic [4:0] reg_i;
    logic [15:0] wdata_i;
    logic busy_o;
    logic done_o;
    logic [15:0] rdata_o;
    logic [3:0] mode_strap_i;
    logic cable_link_i;
    logic [29:0] tree_chain_inputs_i;
    logic tree_test_output_pin_o;
    logic power_down_o;
    logic chip_down_o;
    logic power_saving_o;
    logic nand_tree_o;
    int n_fail;
    int n_checks;
    logic t0; // tree output before a flip
    logic [4:0] rsv [5] = '{5'h0e, 5'h10, 5'h14, 5'h16, 5'h1d}; // reserved slots
    mgmt_if link();
    mgmt_controller #(.DEV_ADDR(5'h01)) u_mgmt_controller (.clk_i(clk_i), .rst_i(rst_i),
        .link(link), .req_i(req_i), .write_i(write_i), .reg_i(reg_i), .wdata_i(wdata_i),
        .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
    // id values are arbitrary
    mgmt_device #(.DEV_ADDR(5'h01), .ID_HIGH(16'h1234), .ID_LOW(16'h5678)) u_mgmt_device (
        .clk_i(clk_i), .rst_i(rst_i), .link(link), .mode_strap_i(mode_strap_i),
        .cable_link_i(cable_link_i), .tree_chain_inputs_i(tree_chain_inputs_i),
        .tree_test_output_pin_o(tree_test_output_pin_o), .power_down_o(power_down_o),
        .chip_down_o(chip_down_o), .power_saving_o(power_saving_o), .nand_tree_o(nand_tree_o));
    mgmt_props u_mgmt_props (.clk_i(clk_i), .rst_i(rst_i), .mdc(link.mdc),
        .mdio_ctl_o(link.mdio_ctl_o), .mdio_ctl_oe(link.mdio_ctl_oe),
        .mdio_dev_o(link.mdio_dev_o), .mdio_dev_oe(link.mdio_dev_oe), .mdio(link.mdio));
    // 25 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // compares and counts
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // prints the verdict and ends the run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one frame: request for one clock, wait for done, let mdc rest
    task automatic frame(input logic wr, input logic [4:0] r, input logic [15:0] d);
        int i;
        @(posedge clk_i);
        req_i <= 1'b1;
        write_i <= wr;
        reg_i <= r;
        wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        for (i = 0; i < 2000 && done_o !== 1'b1; i++) @(negedge clk_i);
        check("frame_done", {15'h0, done_o}, 16'h0001);
        check("busy", {15'h0, busy_o}, 16'h0001);
        repeat (20) @(posedge clk_i);
        check("busy", {15'h0, busy_o}, 16'h0000);
    endtask
    // read a register and compare
    task automatic rd_chk(input string what, input logic [4:0] r, input logic [15:0] exp);
        frame(1'b0, r, 16'h0000);
        check(what, rdata_o, exp);
    endtask
    // hardware reset with a chosen strap setting
    task automatic hw_reset(input logic [3:0] s);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode_strap_i <= s;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // flag outputs widened for comparison
    function automatic logic [15:0] w(input logic b);
        return {15'h0, b};
    endfunction
    // hang guard, well beyond the expected run
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        rst_i = 1'b1;
        req_i = 1'b0;
        write_i = 1'b0;
        reg_i = 5'h00;
        wdata_i = 16'h0000;
        mode_strap_i = 4'h0;
        cable_link_i = 1'b0;
        tree_chain_inputs_i = 30'h3fffffff;
        n_fail = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("power_saving", w(power_saving_o), 16'h0001);
        rd_chk("basic_control", `REG_BASIC_CONTROL, `RST_BASIC_CONTROL);
        rd_chk("basic_status", `REG_BASIC_STATUS, `RST_BASIC_STATUS);
        rd_chk("id_high", `REG_ID_HIGH, 16'h1234);
        rd_chk("id_low", `REG_ID_LOW, 16'h5678);
        cable_link_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("power_saving", w(power_saving_o), 16'h0000);
        // software power down and back, registers stay reachable
        frame(1'b1, `REG_BASIC_CONTROL, 16'h1800);
        check("power_down", w(power_down_o), 16'h0001);
        rd_chk("basic_control", `REG_BASIC_CONTROL, 16'h1800);
        frame(1'b1, `REG_BASIC_CONTROL, 16'h1000);
        check("power_down", w(power_down_o), 16'h0000);
        // soft reset written together with the power down bit self clears
        frame(1'b1, `REG_BASIC_CONTROL, 16'h9800);
        rd_chk("basic_control", `REG_BASIC_CONTROL, `RST_BASIC_CONTROL);
        // no saving with negotiation off, even without link
        cable_link_i <= 1'b0;
        frame(1'b1, `REG_BASIC_CONTROL, 16'h0000);
        check("power_saving", w(power_saving_o), 16'h0000);
        frame(1'b1, `REG_BASIC_CONTROL, 16'h1000);
        check("power_saving", w(power_saving_o), 16'h0001);
        // plain rw, read-only and reserved places
        frame(1'b1, `REG_ADVERTISE, 16'ha5a5);
        rd_chk("advertise", `REG_ADVERTISE, 16'ha5a5);
        frame(1'b1, `REG_BASIC_STATUS, 16'hffff);
        rd_chk("basic_status", `REG_BASIC_STATUS, `RST_BASIC_STATUS);
        foreach (rsv[i]) begin
            frame(1'b1, rsv[i], 16'hffff);
            rd_chk("reserved", rsv[i], 16'h0000);
        end
        // extended access: analog test write then read back
        check("nand_tree", w(nand_tree_o), 16'h0000);
        frame(1'b1, `REG_EXT_CONTROL, 16'h8107);
        frame(1'b1, `REG_EXT_WRITE, 16'hbeef);
        frame(1'b1, `REG_EXT_CONTROL, 16'h0107);
        rd_chk("analog_test", `REG_EXT_READ, 16'hbeef);
        frame(1'b1, `REG_EXT_CONTROL, 16'h8102);
        frame(1'b1, `REG_EXT_WRITE, `OVERRIDE_NAND_TREE);
        check("nand_tree", w(nand_tree_o), 16'h0001);
        frame(1'b1, `REG_EXT_CONTROL, 16'h0102);
        rd_chk("op_override", `REG_EXT_READ, `OVERRIDE_NAND_TREE);
        // reset drops the override; tree output idle low
        hw_reset(4'h0);
        check("nand_tree", w(nand_tree_o), 16'h0000);
        check("tree_out", w(tree_test_output_pin_o), 16'h0000);
        // straps select the tree; first input flips the output
        hw_reset(`MODE_NAND_TREE);
        check("nand_tree", w(nand_tree_o), 16'h0001);
        // captured straps read back through the extended space
        frame(1'b1, `REG_EXT_CONTROL, 16'h0103);
        rd_chk("op_mode_status", `REG_EXT_READ, {12'h000, `MODE_NAND_TREE});
        t0 = tree_test_output_pin_o;
        tree_chain_inputs_i <= 30'h3ffffffe;
        repeat (3) @(posedge clk_i);
        check("tree_first", w(tree_test_output_pin_o), w(~t0));
        // a low last input forces one and hides the first
        tree_chain_inputs_i <= 30'h1fffffff;
        repeat (3) @(posedge clk_i);
        check("tree_last", w(tree_test_output_pin_o), 16'h0001);
        tree_chain_inputs_i <= 30'h1ffffffe;
        repeat (3) @(posedge clk_i);
        check("tree_last", w(tree_test_output_pin_o), 16'h0001);
        // chip power down entered and left by reset only
        hw_reset(`MODE_CHIP_DOWN);
        check("chip_down", w(chip_down_o), 16'h0001);
        hw_reset(4'h0);
        check("chip_down", w(chip_down_o), 16'h0000);
        final_report();
    end
endmodule // tb_top
